// file: acr_channel_ctrl.sv
// Per-channel interrupt and result registers, shared result formatting and first channel input scan behind an APB slave
`timescale 1ns/1ps
`default_nettype none

module acr_channel_ctrl
  import acr_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int NUM_CH = 4
)
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output var  logic [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Converter core side
  input  wire acr_conv_s          conv_in,
  output var  logic [3:0]         first_channel_mux,
  // Interrupt controller side
  input  wire logic [NUM_CH-1:0]  vector_taken,
  output logic [NUM_CH-1:0]       irq_request,
  output logic [2*NUM_CH-1:0]     irq_level
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]          format_ctrl;
  logic [15:0]         compare_threshold;
  logic [3:0]          positive_input_select [NUM_CH];
  acr_irq_ctrl_s       irq_ctrl              [NUM_CH];
  logic [NUM_CH-1:0]   channel_flag;
  logic [15:0]         combined_result       [NUM_CH];
  acr_scan_s           scan;
  logic [7:0]          temp_byte;
  logic [7:0]          next_rdata;
  logic                next_latch;
  logic [7:0]          next_temp;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] fmt_result(input logic [11:0] raw, input logic [1:0] res,
                                             input logic sgn);
    logic [15:0] r;
    r = 16'h0000;
    case (res)
      RES_12_LEFT: r = {raw, 4'h0};
      RES_8_BIT:   r = {{8{sgn & raw[7]}}, raw[7:0]};
      default:     r = {{4{sgn & raw[11]}}, raw};
    endcase
    return r;
  endfunction

  function automatic logic is_less(input logic [15:0] a, input logic [15:0] b, input logic sgn);
    return sgn ? ($signed(a) < $signed(b)) : (a < b);
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [5:0]  idx;
  logic        addr_ok;
  logic        is_chan;
  logic [1:0]  sel_ch;
  logic [2:0]  sel_reg;
  logic        wr_en;
  logic        rd_done;
  logic        wr_byte;

  assign idx     = paddr[7:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:8] == '0);
  assign is_chan = idx[5];
  assign sel_ch  = idx[4:3];
  assign sel_reg = idx[2:0];
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_done = psel && penable && !pwrite && addr_ok;
  assign wr_byte = wr_en && pstrb[0];

  function automatic logic chan_hit(input logic [2:0] r);
    return is_chan && (sel_reg == r) && (int'(sel_ch) < NUM_CH);
  endfunction

  function automatic logic low_read(output logic [1:0] ch);
    ch = sel_ch;
    if (!is_chan && idx[5:3] == IDX_RESULT_MIRROR[5:3] && !idx[0])
    begin
      ch = idx[2:1];
      return 1'b1;
    end
    return chan_hit(CH_RESULT_LOW);
  endfunction

  function automatic logic high_read();
    return (!is_chan && idx[5:3] == IDX_RESULT_MIRROR[5:3] && idx[0]) || chan_hit(CH_RESULT_HIGH);
  endfunction

  // Read data is prepared in the setup cycle so prdata comes from a flop
  always_comb
  begin
    logic [1:0] lch;
    lch        = 2'b00;
    next_rdata = 8'h00;
    next_latch = 1'b0;
    next_temp  = temp_byte;
    if (low_read(lch))
    begin
      next_rdata = combined_result[lch][7:0];
      next_latch = 1'b1;
      next_temp  = combined_result[lch][15:8];
    end
    else if (high_read())
      next_rdata = temp_byte;
    else if (!is_chan)
    begin
      case (idx)
        IDX_FORMAT_CTRL: next_rdata = format_ctrl;
        IDX_THRESH_LOW:  next_rdata = compare_threshold[7:0];
        IDX_THRESH_HIGH: next_rdata = compare_threshold[15:8];
        default:         next_rdata = 8'h00;
      endcase
    end
    else if (int'(sel_ch) < NUM_CH)
    begin
      case (sel_reg)
        CH_MUX_CTRL:  next_rdata = {1'b0, positive_input_select[sel_ch], 3'b000};
        CH_IRQ_CTRL:  next_rdata = {4'h0, irq_ctrl[sel_ch]};
        CH_IRQ_FLAG:  next_rdata = {7'h00, channel_flag[sel_ch]};
        CH_SCAN_CTRL: next_rdata = (sel_ch == 2'd0) ? scan : 8'h00;
        default:      next_rdata = 8'h00;
      endcase
    end
    if (!addr_ok)
    begin
      next_rdata = 8'h00;
      next_latch = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= {24'h00_0000, next_rdata};
  end

  // Temp byte is taken at the completing edge of a low-byte read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      temp_byte <= RESET_BYTE;
    else if (rd_done && next_latch)
      temp_byte <= next_temp;
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      format_ctrl       <= RESET_BYTE;
      compare_threshold <= RESET_WORD;
    end
    else if (wr_byte && !is_chan)
    begin
      if (idx == IDX_FORMAT_CTRL)
        format_ctrl <= pwdata[7:0] & 8'h16;
      if (idx == IDX_THRESH_LOW)
        compare_threshold[7:0] <= pwdata[7:0];
      if (idx == IDX_THRESH_HIGH)
        compare_threshold[15:8] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        positive_input_select[c] <= 4'h0;
        irq_ctrl[c]              <= '0;
      end
    end
    else if (wr_byte)
    begin
      if (chan_hit(CH_MUX_CTRL))
        positive_input_select[sel_ch] <= pwdata[POS_MUX_LSB+3:POS_MUX_LSB];
      if (chan_hit(CH_IRQ_CTRL))
        irq_ctrl[sel_ch] <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Conversion results and flag conditions
  // ----------------------------------------------------------------
  logic [1:0]  res_sel;
  logic        signed_mode;
  logic [15:0] new_result;
  logic [NUM_CH-1:0] flag_set;

  assign res_sel     = format_ctrl[FMT_RES_LSB+1:FMT_RES_LSB];
  assign signed_mode = format_ctrl[FMT_SIGNED_BIT];
  assign new_result  = fmt_result(conv_in.raw, res_sel, signed_mode);

  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      flag_set[c] = 1'b0;
      if (conv_in.valid && int'(conv_in.channel) == c)
      begin
        case (irq_ctrl[c].irq_condition_select)
          MODE_COMPLETE: flag_set[c] = 1'b1;
          MODE_BELOW:    flag_set[c] = is_less(new_result, compare_threshold, signed_mode);
          MODE_ABOVE:    flag_set[c] = is_less(compare_threshold, new_result, signed_mode);
          default:       flag_set[c] = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int c = 0; c < NUM_CH; c++)
        combined_result[c] <= RESET_WORD;
    end
    else if (conv_in.valid && int'(conv_in.channel) < NUM_CH)
      combined_result[conv_in.channel] <= new_result;
  end

  // Set beats a clear in the same cycle so no event is lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_flag <= '0;
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (flag_set[c])
          channel_flag[c] <= 1'b1;
        else if (vector_taken[c])
          channel_flag[c] <= 1'b0;
        else if (wr_byte && chan_hit(CH_IRQ_FLAG) && int'(sel_ch) == c && pwdata[FLAG_BIT])
          channel_flag[c] <= 1'b0;
      end
    end
  end

  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      irq_request[c]       = channel_flag[c] && (irq_ctrl[c].irq_priority_level != 2'b00);
      irq_level[2*c +: 2]  = irq_ctrl[c].irq_priority_level;
    end
  end

  // ----------------------------------------------------------------
  // First channel input scan
  // ----------------------------------------------------------------
  logic first_conv;
  assign first_conv = conv_in.valid && (conv_in.channel == 2'd0);

  // A write wins over a conversion in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      scan <= '0;
    else if (wr_byte && chan_hit(CH_SCAN_CTRL) && sel_ch == 2'd0)
    begin
      scan.count  <= pwdata[3:0];
      scan.offset <= 4'h0;
    end
    else if (first_conv && scan.count != 4'h0)
    begin
      if (scan.offset == scan.count)
        scan.offset <= 4'h0;
      else
        scan.offset <= scan.offset + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      first_channel_mux <= 4'h0;
    else
      first_channel_mux <= positive_input_select[0] + scan.offset;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_first_conv_scanning;
    first_conv && scan.count != 4'h0 && !(wr_byte && chan_hit(CH_SCAN_CTRL));
  endsequence

  a_req_follows_flag: assert property (@(posedge pclk) disable iff (!presetn)
    flag_set[0] && irq_ctrl[0].irq_priority_level != 2'b00 && !wr_en |=> irq_request[0])
    else $error("enabled channel set no request");

  a_complete_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    conv_in.valid && conv_in.channel == 2'd1 && irq_ctrl[1].irq_condition_select == MODE_COMPLETE
    |=> channel_flag[1])
    else $error("conversion complete did not set flag");

  a_reserved_mode_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !channel_flag[2] && irq_ctrl[2].irq_condition_select == 2'b10 && !(wr_en) |=> !channel_flag[2])
    else $error("reserved mode set the flag");

  a_vector_clears_flag: assert property (@(posedge pclk) disable iff (!presetn)
    vector_taken[0] && !flag_set[0] |=> !channel_flag[0])
    else $error("vector did not clear flag");

  a_flag_w1c: assert property (@(posedge pclk) disable iff (!presetn)
    wr_byte && chan_hit(CH_IRQ_FLAG) && sel_ch == 2'd0 && !pwdata[0] && !vector_taken[0] && channel_flag[0]
    |=> channel_flag[0])
    else $error("writing zero changed the flag");

  a_scan_wraps: assert property (@(posedge pclk) disable iff (!presetn)
    s_first_conv_scanning and (scan.offset == scan.count) |=> scan.offset == 4'h0)
    else $error("scan offset did not wrap");

  a_scan_steps: assert property (@(posedge pclk) disable iff (!presetn)
    s_first_conv_scanning and (scan.offset != scan.count) |=> scan.offset == $past(scan.offset) + 4'h1)
    else $error("scan offset did not step");

  a_scan_idle: assert property (@(posedge pclk) disable iff (!presetn)
    scan.count == 4'h0 && !wr_en |=> $stable(scan.offset))
    else $error("offset moved without scanning");

  a_mux_sum: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 first_channel_mux == 4'($past(positive_input_select[0]) + $past(scan.offset)))
    else $error("first channel mux is not base plus offset");

  a_left_format: assert property (@(posedge pclk) disable iff (!presetn)
    conv_in.valid && conv_in.channel == 2'd0 && res_sel == RES_12_LEFT
    |=> combined_result[0][3:0] == 4'h0 && combined_result[0][15:4] == $past(conv_in.raw))
    else $error("left adjusted result misplaced");

  a_right_sign: assert property (@(posedge pclk) disable iff (!presetn)
    conv_in.valid && conv_in.channel == 2'd0 && res_sel == RES_12_RIGHT
    |=> combined_result[0][15:12] == {4{$past(signed_mode) & $past(conv_in.raw[11])}})
    else $error("right adjusted upper nibble wrong");

  a_scan_write_zero: assert property (@(posedge pclk) disable iff (!presetn)
    wr_byte && chan_hit(CH_SCAN_CTRL) && sel_ch == 2'd0 |=> scan.offset == 4'h0)
    else $error("scan write left offset nonzero");

endmodule // acr_channel_ctrl

`default_nettype wire

// file: acr_channel_ctrl_tb.sv
// Self-checking testbench for the converter channel control block
`timescale 1ns/1ps
`default_nettype none

module acr_channel_ctrl_tb
  import acr_pkg::*;
;
  // ------------------------------------------------------------
  // Signals and tables
  // ------------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  acr_conv_s   conv_in;
  logic [3:0]  first_channel_mux;
  logic [3:0]  vector_taken;
  logic [3:0]  irq_request;
  logic [7:0]  irq_level;
  logic [31:0] exp_q[$];
  int          n_errors;
  int          n_compared;
  logic [1:0]  t_mode[8] = '{MODE_COMPLETE, MODE_COMPLETE, MODE_BELOW, MODE_BELOW, MODE_ABOVE, MODE_ABOVE,
                             2'b10, MODE_BELOW};
  logic [1:0]  t_lvl[8]  = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3, 2'h1, 2'h0};
  logic [11:0] t_raw[8]  = '{12'h123, 12'hfff, 12'h7ff, 12'h800, 12'h801, 12'h800, 12'h456, 12'h000};
  logic        t_set[8]  = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [1:0]  t_res[3]  = '{RES_12_RIGHT, RES_8_BIT, RES_12_LEFT};

  acr_channel_ctrl #(.ADDR_W(12), .NUM_CH(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_in(conv_in), .first_channel_mux(first_channel_mux), .vector_taken(vector_taken),
    .irq_request(irq_request), .irq_level(irq_level)
  );

  always #5 pclk = ~pclk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [5:0] ci(input int c, input logic [2:0] r);
    return IDX_CHAN_BASE + 6'(8 * c) + 6'(r);
  endfunction

  function automatic logic [15:0] fmt(input logic [1:0] res, input logic s, input logic [11:0] raw);
    if (res == RES_12_LEFT)
      return {raw, 4'h0};
    if (res == RES_8_BIT)
      return {{8{s & raw[7]}}, raw[7:0]};
    return {{4{s & raw[11]}}, raw};
  endfunction

  task automatic final_report;
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // Upper data bits are noise on purpose: only the low byte may matter
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d, input logic [3:0] st);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'($urandom), d};
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      n_errors++;
      final_report();
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb({4'h0, idx, 2'b00}, 1'b1, d, 4'hf);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    apb({4'h0, idx, 2'b00}, 1'b0, 8'h00, 4'hf);
  endtask

  // One-cycle conversion pulse; returns at the negedge after the sampling edge, half a cycle before first_channel_mux follows
  task automatic conv(input int c, input logic [11:0] raw);
    @(posedge pclk);
    conv_in <= '{valid: 1'b1, channel: 2'(c), raw: raw};
    @(posedge pclk);
    conv_in.valid <= 1'b0;
    @(negedge pclk);
  endtask

  // ------------------------------------------------------------
  // Read data monitor
  // ------------------------------------------------------------
  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1 && exp_q.size() > 0)
    begin
      chk($sformatf("prdata at %h", paddr), exp_q.pop_front(), prdata);
      chk("pslverr", 32'h0000_0000, {31'h0, pslverr});
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [11:0] raw;
    logic [1:0]  res;
    logic        sg;
    logic [15:0] ex;
    int          c;
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; pstrb = 4'hf; conv_in = '0; vector_taken = 4'h0;
    n_errors = 0;
    n_compared = 0;
    raw = 12'($urandom(22));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int ch = 0; ch < 4; ch++)
      for (int r = 1; r < 8; r++)
        rd(ci(ch, 3'(r)), RESET_BYTE);
    // Refused accesses: misaligned write, strobe off, write to result
    apb({4'h0, ci(1, CH_IRQ_CTRL), 2'b10}, 1'b1, 8'h0f, 4'hf);
    apb({4'h0, ci(1, CH_IRQ_CTRL), 2'b00}, 1'b1, 8'h0f, 4'he);
    rd(ci(1, CH_IRQ_CTRL), 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      res = t_res[i % 3];
      sg  = 1'((i / 3) % 2);
      c   = i % 4;
      raw = 12'($urandom);
      raw[11] = 1'(i / 6);
      raw[7]  = 1'(i / 6);
      ex  = fmt(res, sg, raw);
      wr(IDX_FORMAT_CTRL, {3'b000, sg, 1'b0, res, 1'b0});
      conv(c, raw);
      wr(ci(c, CH_RESULT_LOW), 8'hff);
      rd(ci(c, CH_RESULT_LOW), ex[7:0]);
      rd(ci(c, CH_RESULT_HIGH), ex[15:8]);
      rd(IDX_RESULT_MIRROR + 6'(2 * c), ex[7:0]);
      rd(IDX_RESULT_MIRROR + 6'(2 * c + 1), ex[15:8]);
    end
    rd(ci(0, CH_SCAN_CTRL), 8'h00);
    // ----- Interrupt modes, levels and flag clearing -----
    wr(IDX_FORMAT_CTRL, 8'h00);
    wr(IDX_THRESH_LOW, 8'h00);
    wr(IDX_THRESH_HIGH, 8'h08);
    for (int ch = 0; ch < 4; ch++)
      wr(ci(ch, CH_IRQ_FLAG), 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      c = i % 4;
      wr(ci(c, CH_IRQ_CTRL), {4'h0, t_mode[i], t_lvl[i]});
      rd(ci(c, CH_IRQ_CTRL), {4'h0, t_mode[i], t_lvl[i]});
      conv(c, t_raw[i]);
      chk("irq_request", {31'h0, t_set[i] & (t_lvl[i] != 2'h0)}, {31'h0, irq_request[c]});
      chk("irq_level", {30'h0, t_lvl[i]}, {30'h0, irq_level[2*c +: 2]});
      rd(ci(c, CH_IRQ_FLAG), {7'h00, t_set[i]});
      if (i % 2 == 0)
      begin
        wr(ci(c, CH_IRQ_FLAG), 8'h00);
        rd(ci(c, CH_IRQ_FLAG), {7'h00, t_set[i]});
        wr(ci(c, CH_IRQ_FLAG), 8'h01);
      end
      else
      begin
        @(posedge pclk);
        vector_taken[c] <= 1'b1;
        @(posedge pclk);
        vector_taken <= 4'h0;
      end
      @(negedge pclk);
      chk("irq_request", 32'h0000_0000, {31'h0, irq_request[c]});
      rd(ci(c, CH_IRQ_FLAG), 8'h00);
    end
    // ----- First channel input scan -----
    wr(ci(0, CH_MUX_CTRL), 8'h28);
    wr(ci(0, CH_SCAN_CTRL), 8'hf2);
    rd(ci(0, CH_SCAN_CTRL), 8'h02);
    @(negedge pclk);
    chk("first_channel_mux", 32'h0000_0005, {28'h0, first_channel_mux});
    for (int k = 1; k <= 7; k++)
    begin
      conv(0, 12'($urandom));
      @(negedge pclk);
      chk("first_channel_mux", 32'(5 + k % 3), {28'h0, first_channel_mux});
      rd(ci(0, CH_SCAN_CTRL), {4'(k % 3), 4'h2});
    end
    conv(1, 12'($urandom));
    rd(ci(0, CH_SCAN_CTRL), 8'h12);
    wr(ci(0, CH_SCAN_CTRL), 8'h03);
    rd(ci(0, CH_SCAN_CTRL), 8'h03);
    wr(ci(1, CH_SCAN_CTRL), 8'h33);
    rd(ci(1, CH_SCAN_CTRL), 8'h00);
    repeat (3) @(posedge pclk);
    if (exp_q.size() != 0)
      n_errors++;
    final_report();
  end

endmodule // acr_channel_ctrl_tb

`default_nettype wire

// file: acr_pkg.sv
// Constants, types and register map for the converter channel control block
`default_nettype none

package acr_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_FORMAT_CTRL   = 6'h01;
  localparam logic [5:0] IDX_RESULT_MIRROR = 6'h10;
  localparam logic [5:0] IDX_THRESH_LOW    = 6'h18;
  localparam logic [5:0] IDX_THRESH_HIGH   = 6'h19;
  localparam logic [5:0] IDX_CHAN_BASE     = 6'h20;
  localparam logic [2:0] CH_MUX_CTRL       = 3'h1;
  localparam logic [2:0] CH_IRQ_CTRL       = 3'h2;
  localparam logic [2:0] CH_IRQ_FLAG       = 3'h3;
  localparam logic [2:0] CH_RESULT_LOW     = 3'h4;
  localparam logic [2:0] CH_RESULT_HIGH    = 3'h5;
  localparam logic [2:0] CH_SCAN_CTRL      = 3'h6;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         POS_MUX_LSB       = 3;
  localparam int         FMT_SIGNED_BIT    = 4;
  localparam int         FMT_RES_LSB       = 1;
  localparam int         FLAG_BIT          = 0;
  localparam logic [7:0] RESET_BYTE        = 8'h00;
  localparam logic [15:0] RESET_WORD       = 16'h0000;

  // Result format codes of the format control register
  localparam logic [1:0] RES_12_RIGHT      = 2'h0;
  localparam logic [1:0] RES_8_BIT         = 2'h2;
  localparam logic [1:0] RES_12_LEFT       = 2'h3;

  // Interrupt condition codes
  localparam logic [1:0] MODE_COMPLETE     = 2'h0;
  localparam logic [1:0] MODE_BELOW        = 2'h1;
  localparam logic [1:0] MODE_ABOVE        = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] irq_condition_select;
    logic [1:0] irq_priority_level;
  } acr_irq_ctrl_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] channel;
    logic [11:0] raw;
  } acr_conv_s;

  typedef struct packed {
    logic [3:0] offset;
    logic [3:0] count;
  } acr_scan_s;

endpackage

`default_nettype wire
